// ==== rtl/stream_rx_pkg.sv ====
// Package: register map, status layout and constants of the stream receiver
package stream_rx_pkg;
	localparam logic [7:0] SYNC_BYTE = 8'h47;
	localparam logic [9:0] COMMA_NEG = 10'h0fa;
	localparam logic [9:0] COMMA_POS = 10'h305;
	localparam int LEN_SHORT = 188;
	localparam int LEN_LONG = 204;
	localparam int ERR_LIMIT = 4;
	localparam int COMMA_NEED = 2;
	localparam int ST_VALID = 0;
	localparam int ST_SOP = 1;
	localparam int ST_EOP = 2;
	localparam int ST_ERR = 3;
	localparam int ST_LOCK_LO = 4;
	localparam int ST_LOCK_HI = 5;
	localparam int ST_POL = 6;
	localparam int ST_WORD = 7;
	localparam logic [1:0] LOCK_NONE = 2'h0;
	localparam logic [1:0] LOCK_204 = 2'h1;
	localparam logic [1:0] LOCK_188 = 2'h3;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_TX_WORD = 8'h10;
	localparam logic [7:0] ADDR_CAL = 8'h14;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef struct packed {
		logic [9:0] code;
		logic valid;
	} code_group_type;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] status;
	} stream_out_type;

	typedef enum logic [1:0] {HUNT, TRACK, LOCKED} pkt_state_type;
endpackage : stream_rx_pkg

// ==== rtl/stream_rx_out.sv ====
// Receiver output stage: word sync, 8b10b decode, packet sync, status
//
// Overview of operation
// RULE1: Decoded byte presented as parallel word
// RULE2: Parallel byte clock driven to downstream
// RULE3: Status bit 0 marks valid data
// RULE4: Status bit 1 marks packet start
// RULE5: Status bit 2 marks packet end
// RULE6: Status bit 3 reports receiver error
// RULE7: Bits 5:4 encode lock state
// RULE8: Bit 6 reports serial polarity
// RULE9: Bit 7 flags every decoded word
// RULE10: Raw code groups output before decoding
// RULE11: Valid strobe accompanies raw code groups
// RULE12: Transmit encoded word on dedicated port
// RULE13: 17-bit calibration return path provided
// RULE14: Integrator attaches external calibration controller
// RULE15: Lock only on sync at 188/204
// RULE16: Missing sync flags error, restarts search
// RULE17: Two clean commas gain word sync
// RULE18: Four errors drop sync, stop writes
// RULE19: Status updates with data, same clock
`timescale 1ns/1ns
module stream_rx_out
	import stream_rx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	input wire stream_rx_pkg::code_group_type code_in,
	input wire logic [16:0] cal_from_xcvr,
	output logic [9:0] cal_to_ctrl,
	output stream_rx_pkg::stream_out_type stream_out,
	output logic data_clk,
	output stream_rx_pkg::code_group_type raw_out,
	output logic [9:0] tx_encoded,
	output logic word_sync,
	output logic irq
);
	import stream_rx_pkg::*;

	// Input code group: two-stage synchroniser
	code_group_type sync1_reg, sync2_reg;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= code_in;
			sync2_reg <= sync1_reg;
		end

	logic [16:0] cal1_reg, cal2_reg;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			cal1_reg <= '0;
			cal2_reg <= '0;
		end
		else
		begin
			cal1_reg <= cal_from_xcvr;
			cal2_reg <= cal1_reg;
		end

	// Raw group passthrough, registered
	code_group_type raw_reg;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			raw_reg <= '0;
		else
			raw_reg <= sync2_reg; // RULE10 RULE11
	assign raw_out = raw_reg;

	// Simplified 8b10b decode: data from low 8 bits, errors by disparity
	wire in_valid = sync2_reg.valid;
	wire [9:0] cg = sync2_reg.code;
	wire [3:0] ones = 4'(cg[0]) + 4'(cg[1]) + 4'(cg[2]) + 4'(cg[3])
		+ 4'(cg[4]) + 4'(cg[5]) + 4'(cg[6]) + 4'(cg[7])
		+ 4'(cg[8]) + 4'(cg[9]);
	wire is_comma = (cg == COMMA_NEG) || (cg == COMMA_POS);
	wire code_err = (ones != 4'h5) && (ones != 4'h4) && (ones != 4'h6);
	logic rd_reg;
	wire disp_err = (ones == 4'h6 && rd_reg) || (ones == 4'h4 && !rd_reg);
	wire bad = code_err || disp_err;
	logic [7:0] ctrl_reg;
	wire [7:0] dec_byte = cg[7:0] ^ {8{ctrl_reg[0]}};

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rd_reg <= 1'b0;
		else if (in_valid && ones != 4'h5 && !code_err)
			rd_reg <= (ones == 4'h6);

	// Word synchronisation
	logic [1:0] comma_reg;
	logic [2:0] err_reg;
	logic sync_reg;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			comma_reg <= '0;
			err_reg <= '0;
			sync_reg <= 1'b0;
		end
		else if (in_valid)
		begin
			comma_reg <= (is_comma && !bad) ?
				((comma_reg == 2'(COMMA_NEED)) ? comma_reg : comma_reg + 2'h1)
				: 2'h0; // RULE17
			err_reg <= bad ? ((err_reg == 3'(ERR_LIMIT)) ? err_reg
				: err_reg + 3'h1) : 3'h0;
			if (!sync_reg && is_comma && !bad && comma_reg == 2'h1)
				sync_reg <= 1'b1; // RULE17
			else if (sync_reg && bad && err_reg == 3'(ERR_LIMIT - 1))
				sync_reg <= 1'b0; // RULE18
		end
	assign word_sync = sync_reg;

	// Decoded word gated by sync; commas are not data
	wire word_ok = in_valid && sync_reg && !bad && !is_comma; // RULE18

	// Packet synchronisation
	pkt_state_type state_reg, state_next;
	logic [7:0] cnt_reg;
	logic [1:0] lock_reg;
	wire is_sync = word_ok && dec_byte == SYNC_BYTE;
	wire at188 = cnt_reg == 8'(LEN_SHORT);
	wire at204 = cnt_reg == 8'(LEN_LONG);
	wire hit = is_sync && (at188 || at204); // RULE15
	wire miss = word_ok && !is_sync && at204
		&& state_reg != HUNT; // RULE16
	wire early_bad = word_ok && is_sync && !at188 && !at204
		&& state_reg != HUNT;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			HUNT: if (is_sync) state_next = TRACK;
			TRACK, LOCKED:
				if (hit) state_next = LOCKED;
				else if (miss || early_bad) state_next = HUNT; // RULE16
			default: state_next = HUNT;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			state_reg <= HUNT;
			cnt_reg <= '0;
			lock_reg <= LOCK_NONE;
		end
		else
		begin
			if (!sync_reg)
				state_reg <= HUNT;
			else
				state_reg <= state_next;
			if (word_ok)
				cnt_reg <= is_sync ? 8'h1 : cnt_reg + 8'h1;
			if (!sync_reg || miss || early_bad)
				lock_reg <= LOCK_NONE;
			else if (hit)
				lock_reg <= at188 ? LOCK_188 : LOCK_204; // RULE7 RULE15
		end

	// Output byte and status vector, same register stage
	stream_out_type out_reg;
	logic [7:0] st;
	always_comb
	begin
		st = '0;
		st[ST_VALID] = word_ok && state_reg == LOCKED; // RULE3
		st[ST_SOP] = is_sync; // RULE4
		st[ST_EOP] = hit; // RULE5
		st[ST_ERR] = miss || early_bad; // RULE6
		st[ST_LOCK_HI:ST_LOCK_LO] = lock_reg; // RULE7
		st[ST_POL] = ctrl_reg[0]; // RULE8
		st[ST_WORD] = in_valid && !bad && !is_comma; // RULE9
	end
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			out_reg <= '0;
		else
			out_reg <= '{data: dec_byte, status: st}; // RULE1 RULE19
	assign stream_out = out_reg;
	assign data_clk = hclk; // RULE2

	// Interrupts: sticky SOP/EOP/ERR, write one clears, set wins
	logic [2:0] ist_reg, imask_reg;
	wire [2:0] ev = {st[ST_ERR], st[ST_EOP], st[ST_SOP]};
	assign irq = |(ist_reg & imask_reg);

	// AHB-Lite slave, zero wait states
	logic [7:0] a_reg;
	logic wr_reg, rd_ph_reg;
	logic [9:0] txw_reg;
	logic [9:0] cal_reg;
	wire take = hsel && hready && htrans == HTRANS_NONSEQ;
	wire do_wr = wr_reg;
	wire w_ctrl = do_wr && a_reg == ADDR_CTRL;
	wire w_clr = do_wr && a_reg == ADDR_IRQ_STAT;
	wire w_mask = do_wr && a_reg == ADDR_IRQ_MASK;
	wire w_tx = do_wr && a_reg == ADDR_TX_WORD;
	wire w_cal = do_wr && a_reg == ADDR_CAL;
	wire [2:0] ist_next = ev | (ist_reg & ~(w_clr ? hwdata[2:0] : 3'h0));

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			a_reg <= '0;
			wr_reg <= 1'b0;
			rd_ph_reg <= 1'b0;
		end
		else
		begin
			wr_reg <= take && hwrite;
			rd_ph_reg <= take && !hwrite;
			if (take)
				a_reg <= haddr[7:0];
		end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			ctrl_reg <= '0;
			ist_reg <= IRQ_RESET;
			imask_reg <= IRQ_RESET;
			txw_reg <= '0;
			cal_reg <= '0;
		end
		else
		begin
			ist_reg <= ist_next;
			if (w_ctrl)
				ctrl_reg <= hwdata[7:0];
			if (w_mask)
				imask_reg <= hwdata[2:0];
			if (w_tx)
				txw_reg <= hwdata[9:0]; // RULE12
			if (w_cal)
				cal_reg <= hwdata[9:0]; // RULE14
		end
	assign tx_encoded = txw_reg; // RULE12
	assign cal_to_ctrl = cal_reg;

	wire [31:0] rd_status = {22'h0, lock_reg, sync_reg, state_reg,
		out_reg.status[ST_POL], out_reg.status[ST_ERR], 3'h0};
	logic [31:0] rmux;
	always_comb
	begin
		if (a_reg == ADDR_CTRL)
			rmux = {24'h0, ctrl_reg};
		else if (a_reg == ADDR_STATUS)
			rmux = rd_status;
		else if (a_reg == ADDR_IRQ_STAT)
			rmux = {29'h0, ist_reg};
		else if (a_reg == ADDR_IRQ_MASK)
			rmux = {29'h0, imask_reg};
		else if (a_reg == ADDR_TX_WORD)
			rmux = {22'h0, txw_reg};
		else if (a_reg == ADDR_CAL)
			rmux = {15'h0, cal2_reg}; // RULE13
		else
			rmux = 32'h0;
	end
	assign hrdata = rd_ph_reg ? rmux : 32'h0;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	// Checks
	sequence clean_comma;
		in_valid && is_comma && !bad;
	endsequence
	sequence two_commas;
		clean_comma ##1 !in_valid ##1 clean_comma;
	endsequence
	AST_SYNC_GAIN: assert property (@(posedge hclk) disable iff (!hresetn)
		!sync_reg ##0 two_commas |=> sync_reg) // RULE17
		else $error("word sync not gained");
	AST_SYNC_LOSS: assert property (@(posedge hclk) disable iff (!hresetn)
		sync_reg && bad && in_valid && err_reg == 3'h3 |=> !sync_reg) // RULE18
		else $error("word sync not dropped");
	AST_NOWORD: assert property (@(posedge hclk) disable iff (!hresetn)
		!sync_reg |-> !word_ok) // RULE18
		else $error("data passed without sync");
	AST_EOP_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
		hit && sync_reg |=> stream_out.status[ST_EOP] &&
		(lock_reg == LOCK_188 || lock_reg == LOCK_204)) // RULE5
		else $error("end of packet without lock");
	AST_LOCK188: assert property (@(posedge hclk) disable iff (!hresetn)
		hit && at188 && sync_reg |=> lock_reg == LOCK_188) // RULE15
		else $error("188 lock missing");
	AST_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
		miss |=> stream_out.status[ST_ERR] && state_reg == HUNT) // RULE16
		else $error("missing sync not flagged");
	AST_SOP: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sync |=> stream_out.status[ST_SOP] &&
		stream_out.data == SYNC_BYTE) // RULE4
		else $error("start of packet not marked");
	AST_VALID: assert property (@(posedge hclk) disable iff (!hresetn)
		stream_out.status[ST_VALID] |-> stream_out.status[ST_WORD]) // RULE3
		else $error("valid without decoded word");
	AST_LOCKCODE: assert property (@(posedge hclk) disable iff (!hresetn)
		stream_out.status[ST_LOCK_HI:ST_LOCK_LO] != 2'h2) // RULE7
		else $error("illegal lock code");
	AST_RAW: assert property (@(posedge hclk) disable iff (!hresetn)
		sync2_reg.valid |=> raw_out.valid && raw_out.code == $past(cg)) // RULE10
		else $error("raw group not forwarded");
	AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(ev & imask_reg)) && !w_mask |=> irq)
		else $error("interrupt lost");
	AST_EARLY_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
		early_bad |=> stream_out.status[ST_ERR] && state_reg == HUNT) // RULE16
		else $error("early sync byte not flagged");
	AST_WORD_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
		in_valid && !bad && !is_comma |=> stream_out.status[ST_WORD]) // RULE9
		else $error("decoded word not flagged");
	AST_IRQ_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		w_clr && hwdata[0] && !ev[0] |=> !ist_reg[0])
		else $error("status bit not cleared");
	AST_TX: assert property (@(posedge hclk) disable iff (!hresetn)
		w_tx |=> tx_encoded == $past(hwdata[9:0])) // RULE12
		else $error("transmit word not presented");
	AST_LOCK204: assert property (@(posedge hclk) disable iff (!hresetn)
		hit && at204 && sync_reg |=> lock_reg == LOCK_204) // RULE15
		else $error("204 lock missing");
	AST_LOCK_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
		!sync_reg |=> lock_reg == LOCK_NONE) // RULE7
		else $error("lock held without word sync");
endmodule : stream_rx_out

// ==== tb/stream_sink.sv ====
// Downstream consumer model: registers bytes, counts status events
`timescale 1ns/1ns
module stream_sink
	import stream_rx_pkg::*;
(
	input wire logic data_clk,
	input wire stream_rx_pkg::stream_out_type stream_in,
	output int sop_count,
	output int eop_count,
	output int err_count,
	output logic [7:0] last_byte
);
	initial
	begin
		sop_count = 0;
		eop_count = 0;
		err_count = 0;
		last_byte = 8'h00;
	end
	// Bytes taken on the output byte clock
	always @(posedge data_clk)
	begin
		if (stream_in.status[ST_WORD])
			last_byte <= stream_in.data;
		if (stream_in.status[ST_SOP])
			sop_count <= sop_count + 1;
		if (stream_in.status[ST_EOP])
			eop_count <= eop_count + 1;
		if (stream_in.status[ST_ERR])
			err_count <= err_count + 1;
	end
endmodule : stream_sink

// ==== tb/tb_asi_receiver_status_outputs.sv ====
// Testbench of the stream receiver output stage
`timescale 1ns/1ns
module tb_asi_receiver_status_outputs;
	import stream_rx_pkg::*;
	logic hclk = 0, hresetn = 0, hwrite = 0, hsel = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, hresp;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, data_clk, word_sync, irq;
	logic [16:0] cal_from_xcvr = 0;
	logic [9:0] cal_to_ctrl, tx_encoded;
	code_group_type code_in = '0, raw_out;
	stream_out_type stream_out;
	int sop_count, eop_count, err_count, mismatches = 0, total_checks = 0;
	int seed = 32'h1847, r, pol = 0;
	logic [7:0] exp_q[$];
	logic [9:0] raw_q[$];
	logic [7:0] sink_byte;
	always #2 hclk = ~hclk;
	stream_rx_out u_dut (.hclk(hclk), .hresetn(hresetn), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .code_in(code_in),
		.cal_from_xcvr(cal_from_xcvr), .cal_to_ctrl(cal_to_ctrl),
		.stream_out(stream_out), .data_clk(data_clk), .raw_out(raw_out),
		.tx_encoded(tx_encoded), .word_sync(word_sync), .irq(irq));
	stream_sink u_sink (.data_clk(data_clk), .stream_in(stream_out),
		.sop_count(sop_count), .eop_count(eop_count),
		.err_count(err_count), .last_byte(sink_byte));
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			check(1, 0);
			end_of_test();
		end
	endtask : wait_ready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		check(hresp, HRESP_OKAY);
		#1;
	endtask : bus
	task send(input logic [9:0] c, input bit data);
		@(posedge hclk);
		code_in <= '{code: c, valid: 1'b1};
		raw_q.push_back(c);
		if (data)
			exp_q.push_back(c[7:0] ^ {8{pol[0]}});
		@(posedge hclk);
		code_in.valid <= 1'b0;
	endtask : send
	task idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle
	task do_reset;
		hresetn <= 0;
		idle(4);
		raw_q.delete();
		exp_q.delete();
		hresetn <= 1;
	endtask : do_reset
	task wsync;
		send(COMMA_NEG, 0);
		send(COMMA_POS, 0);
		idle(6);
		check(word_sync, 1);
	endtask : wsync
	task pkt(input int gap);
		send({2'b01, SYNC_BYTE}, 1);
		repeat (gap - 1)
		begin
			r = $random(seed);
			send({2'b10, r[3:0], ~r[3:0]}, 1);
		end
		send({2'b01, SYNC_BYTE}, 1);
		idle(6);
	endtask : pkt
	always @(posedge hclk)
	begin
		#1;
		if (raw_out.valid === 1'b1 && raw_q.size() > 0)
			check(raw_out.code, raw_q.pop_front());
		if (stream_out.status[ST_WORD] === 1'b1 && exp_q.size() > 0)
			check(stream_out.data, exp_q.pop_front());
	end
	initial
	begin
		repeat (100000) @(posedge hclk);
		mismatches++;
		end_of_test();
	end
	initial
	begin
		do_reset();
		#1;
		check(data_clk, hclk);
		bus(1, ADDR_TX_WORD, 32'h2a5);
		check(tx_encoded, 10'h2a5);
		cal_from_xcvr <= 17'(($random(seed)));
		idle(4);
		bus(0, ADDR_CAL, 0);
		check(rd[16:0], cal_from_xcvr);
		bus(1, ADDR_CAL, 32'h3c9);
		check(cal_to_ctrl, 10'h3c9);
		bus(0, 8'h40, 0);
		check(rd, 0);
		bus(1, ADDR_IRQ_MASK, 32'h7);
		wsync();
		pkt(LEN_SHORT);
		check(stream_out.status[5:4], LOCK_188);
		check(sop_count, 2);
		check(eop_count, 1);
		check(irq, 1);
		bus(0, ADDR_IRQ_STAT, 0);
		check(rd[2:0], 3'h3);
		bus(1, ADDR_IRQ_STAT, 32'h3);
		idle(2);
		check(irq, 0);
		do_reset();
		wsync();
		pkt(LEN_LONG);
		check(stream_out.status[5:4], LOCK_204);
		check(err_count, 0);
		do_reset();
		wsync();
		pkt(100);
		check(err_count, 1);
		check(stream_out.status[5:4], LOCK_NONE);
		check(irq, 0);
		pkt(LEN_LONG + 1);
		check(err_count, 2);
		bus(1, ADDR_CTRL, 32'h1);
		pol = 1;
		send(10'h2c3, 1);
		idle(4);
		check(stream_out.status[ST_POL], 1);
		check(sink_byte, 8'hc3 ^ 8'hff);
		repeat (4) send(10'h000, 0);
		idle(6);
		check(word_sync, 0);
		check(exp_q.size(), 0);
		end_of_test();
	end
endmodule : tb_asi_receiver_status_outputs
